/* File: logic/axis_io_mode_control.sv */
/*
 Discrete input, target selection, loop mode and solenoid PWM logic of a
 cylinder position controller, with an APB register slave.
 Assumes inputs synchronous to clk only after the internal synchroniser,
 and preset, actual position and cable-break flag from an analog front end.
*/
// What this block does
// - Start and stop are active low; the other six inputs are active high.
// - Start begins movement toward preset or stored profile chosen by selection.
// - Without start the latched target holds; selection changes are ignored.
// - Stop halts movement; releasing stop permits movement again.
// - No movement without enable; enable brings the active state.
// - Ramp-off input or zero ramp time bypasses the setpoint ramp.
// - Selection is binary, input 6 lsb; 0 is preset, 1..7 profiles.
// - Nonzero code with start uses profile position, ignoring the preset.
// - Fieldbus variant ignores selection inputs; code comes from software.
// - Both solenoids get 1000 Hz PWM with superimposed dither.
// - Error output is asserted whenever an error is present.
// - In-position output is asserted when the cylinder reaches target.
// - Green shows supply, yellow in position, red error.
// - Closed loop regulates solenoid currents from the position error.
// - Open loop maps 0..50% to Imax..Imin on B, 50..100% to Imin..Imax on A.
// - External mode: controller-off input chooses open or closed loop.
// - Disabled gives no current; mode changes only while disabled.
// - Detected cable break blocks solenoids and raises error and red.
// - Cable-break latency of about 100 ms is tolerated upstream.
`timescale 1ns/10ps
`default_nettype none
`include "axis_io_defs.svh"
module axis_io_mode_control #(
    parameter int PWM_CYC = `CLK_HZ / `PWM_HZ,
    parameter int DITHER_CYC = `CLK_HZ / (2 * `DITHER_HZ)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire axis_io_pkg::din_t din,
    input wire logic [11:0] preset_in,
    input wire logic [11:0] actual_pos,
    input wire logic cable_break_in,
    input wire logic supply_ok,
    output logic sol_a_pwm,
    output logic sol_b_pwm,
    output logic err_out,
    output logic in_pos_out,
    output logic led_green,
    output logic led_yellow,
    output logic led_red,
    output logic ramp_bypass
);
    import axis_io_pkg::*;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Linear current between lo and hi for a fraction of 4096
    function automatic logic [11:0] cur_map(input logic [12:0] f, input logic [11:0] lo,
                                            input logic [11:0] hi);
        logic [24:0] p;
        p = 25'((hi > lo) ? (hi - lo) : 12'h000) * 25'(f);
        return lo + 12'(p >> 12);
    endfunction : cur_map

    // Dither added or removed around the duty, never turning a live output off
    function automatic logic [11:0] dith(input logic [11:0] d, input logic [11:0] a,
                                         input logic up);
        logic [12:0] s;
        s = {1'b0, d} + {1'b0, a};
        if (d == 12'h000) return 12'h000;
        if (up) return s[12] ? 12'hfff : s[11:0];
        return (d > a) ? d - a : 12'h001;
    endfunction : dith

    // ---------------------------------------------------------------
    // Input synchroniser and debounce
    // ---------------------------------------------------------------
    logic [7:0] s1_r, s2_r, stab_r;
    logic [7:0] deb_r [8];
    // Contact bounce on the sequencer lines would otherwise latch false targets
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= `DIN_IDLE;
            s2_r <= `DIN_IDLE;
            stab_r <= `DIN_IDLE;
            for (int i = 0; i < 8; i++) deb_r[i] <= 8'h00;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            for (int i = 0; i < 8; i++) begin
                if (s2_r[i] == stab_r[i]) deb_r[i] <= 8'h00;
                else if (deb_r[i] == 8'(`DEB_CYC - 1)) begin
                    stab_r[i] <= s2_r[i];
                    deb_r[i] <= 8'h00;
                end else deb_r[i] <= deb_r[i] + 8'h01;
            end
        end
    end

    // Active levels of the filtered inputs
    wire start = ~stab_r[0];
    wire stop = ~stab_r[1];
    wire en = stab_r[2];
    wire lbi = stab_r[3];
    wire ramp_off = stab_r[4];
    wire [2:0] prof = stab_r[7:5];

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [1:0] cmode_r;
    logic fb_r, cbe_r, cbs_r;
    logic [2:0] bus_code_r;
    logic [15:0] ramp_r;
    logic [11:0] imin_r, imax_r, win_r, damp_r;
    logic [7:0] kp_r;
    logic [11:0] pmem_r [7];
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    state_t state_r;
    mode_t mode_r;
    logic [2:0] code_r;
    logic [11:0] target_r, setp_r;
    logic err_r;

    wire setup = psel & ~penable;
    wire wr = psel & penable & pready_r & pwrite;
    wire [7:0] pofs = paddr - `OFS_PROF;
    wire prof_hit = paddr >= `OFS_PROF && paddr <= `OFS_PROF_END && paddr[1:0] == 2'h0;
    wire [2:0] pidx = pofs[4:2];
    wire cbs_clr = wr && paddr == `OFS_STAT && pwdata[`STAT_CBS_BIT];

    // Read decode, no wait state; prdata comes from a flop loaded at the end of setup
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        if (paddr == `OFS_CTRL) rd_val = {25'h0, bus_code_r, cbe_r, fb_r, cmode_r};
        else if (paddr == `OFS_RAMP) rd_val = {16'h0, ramp_r};
        else if (paddr == `OFS_CURR) rd_val = {4'h0, imax_r, 4'h0, imin_r};
        else if (paddr == `OFS_LOOP) rd_val = {4'h0, win_r, 8'h0, kp_r};
        else if (paddr == `OFS_DITH) rd_val = {20'h0, damp_r};
        else if (paddr == `OFS_STAT)
            rd_val = {21'h0, in_pos_out, err_r, 1'b0, cbs_r, 1'b0, code_r, mode_r, state_r};
        else if (paddr == `OFS_TGT) rd_val = {4'h0, setp_r, 4'h0, target_r};
        else if (prof_hit) rd_val = {20'h0, pmem_r[pidx]};
        else rd_hit = 1'b0;
    end

    // APB answer: pready in the cycle after setup, slave error on unmapped
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~rd_hit;
            prdata_r <= (setup & ~pwrite) ? rd_val : 32'h0;
        end
    end

    // Register writes; writing one to status bit 8 clears the break flag read at bit 7
    always_ff @(posedge clk) begin
        if (rst) begin
            cmode_r <= MODE_ON;
            {fb_r, cbe_r, bus_code_r} <= 5'h00;
            ramp_r <= 16'h0;
            imin_r <= 12'h000;
            imax_r <= `RST_IMAX;
            kp_r <= `RST_KP;
            win_r <= `RST_WIN;
            damp_r <= 12'h000;
            for (int i = 0; i < 7; i++) pmem_r[i] <= 12'h000;
        end else if (wr) begin
            if (paddr == `OFS_CTRL) {bus_code_r, cbe_r, fb_r, cmode_r} <= pwdata[6:0];
            else if (paddr == `OFS_RAMP) ramp_r <= pwdata[15:0];
            else if (paddr == `OFS_CURR) {imax_r, imin_r} <= {pwdata[27:16], pwdata[11:0]};
            else if (paddr == `OFS_LOOP) {win_r, kp_r} <= {pwdata[27:16], pwdata[7:0]};
            else if (paddr == `OFS_DITH) damp_r <= pwdata[11:0];
            else if (prof_hit && pidx != 3'h7) pmem_r[pidx] <= pwdata[11:0];
        end
    end

    // ---------------------------------------------------------------
    // Enable state, loop mode and target selection
    // ---------------------------------------------------------------
    wire [2:0] sel_code = fb_r ? bus_code_r : prof;
    wire [11:0] sel_tgt = (sel_code == 3'h0) ? preset_in : pmem_r[sel_code - 3'h1];
    wire open_loop = mode_r == MODE_OFF || (mode_r == MODE_EXT && lbi);
    wire cb_now = cbe_r & cable_break_in;
    wire block = stop | (state_r != ST_ACT) | err_r;

    // Mode is taken from software only while disabled, frozen while active
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_DIS;
            mode_r <= MODE_ON;
            code_r <= 3'h0;
            target_r <= 12'h000;
        end else begin
            state_r <= en ? ST_ACT : ST_DIS;
            if (state_r == ST_DIS) mode_r <= mode_t'(cmode_r);
            if (start) begin
                code_r <= sel_code;
                target_r <= sel_tgt;
            end
        end
    end

    // Error from cable break; the detector's own latency is accepted as is
    always_ff @(posedge clk) begin
        if (rst) begin
            err_r <= 1'b0;
            cbs_r <= 1'b0;
        end else begin
            err_r <= cb_now;
            cbs_r <= cb_now | (cbs_r & ~cbs_clr);
        end
    end

    // ---------------------------------------------------------------
    // Setpoint ramp
    // ---------------------------------------------------------------
    logic [15:0] rcnt_r;
    wire bypass = ramp_off | (ramp_r == 16'h0);
    wire rtick = rcnt_r >= ramp_r - 16'h1;
    // Halting on stop freezes the setpoint so release resumes smoothly
    always_ff @(posedge clk) begin
        if (rst) begin
            setp_r <= 12'h000;
            rcnt_r <= 16'h0;
        end else if (!stop) begin
            rcnt_r <= (bypass | rtick) ? 16'h0 : rcnt_r + 16'h1;
            if (bypass) setp_r <= target_r;
            else if (rtick && setp_r < target_r) setp_r <= setp_r + 12'h001;
            else if (rtick && setp_r > target_r) setp_r <= setp_r - 12'h001;
        end
    end

    // ---------------------------------------------------------------
    // Current command
    // ---------------------------------------------------------------
    wire signed [12:0] perr = $signed({1'b0, setp_r}) - $signed({1'b0, actual_pos});
    wire [11:0] pmag = perr[12] ? 12'(-perr) : perr[11:0];
    wire [19:0] pscl = (20'(pmag) * 20'(kp_r)) >> 4;
    wire [12:0] cfrac = (pscl > 20'h1000) ? 13'h1000 : pscl[12:0];
    wire [11:0] cl_cur = (pmag == 12'h000) ? 12'h000 : cur_map(cfrac, imin_r, imax_r);
    wire lo_half = preset_in < 12'h800;
    wire [12:0] ofrac_b = 13'(13'h0800 - {1'b0, preset_in}) << 1;
    wire [12:0] ofrac_a = 13'({1'b0, preset_in} - 13'h0800) << 1;
    logic [11:0] cur_a, cur_b;
    always_comb begin
        if (open_loop) begin
            cur_b = lo_half ? cur_map(ofrac_b, imin_r, imax_r) : 12'h000;
            cur_a = lo_half ? 12'h000 : cur_map(ofrac_a, imin_r, imax_r);
        end else begin
            cur_a = perr[12] ? 12'h000 : cl_cur;
            cur_b = perr[12] ? cl_cur : 12'h000;
        end
    end

    // ---------------------------------------------------------------
    // PWM with dither
    // ---------------------------------------------------------------
    logic [31:0] pcnt_r, dcnt_r, thr_a_r, thr_b_r;
    logic dup_r;
    wire [11:0] da = dith(cur_a, damp_r, dup_r);
    wire [11:0] db = dith(cur_b, damp_r, dup_r);
    // Duty threshold registered so blocking reaches the pins in two cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            pcnt_r <= 32'h0;
            dcnt_r <= 32'h0;
            dup_r <= 1'b0;
            thr_a_r <= 32'h0;
            thr_b_r <= 32'h0;
        end else begin
            pcnt_r <= (pcnt_r == 32'(PWM_CYC - 1)) ? 32'h0 : pcnt_r + 32'h1;
            dcnt_r <= (dcnt_r == 32'(DITHER_CYC - 1)) ? 32'h0 : dcnt_r + 32'h1;
            if (dcnt_r == 32'(DITHER_CYC - 1)) dup_r <= ~dup_r;
            thr_a_r <= block ? 32'h0 : (32'(da) * 32'(PWM_CYC)) >> 12;
            thr_b_r <= block ? 32'h0 : (32'(db) * 32'(PWM_CYC)) >> 12;
        end
    end

    // ---------------------------------------------------------------
    // Output flops
    // ---------------------------------------------------------------
    wire [11:0] tdiff = (target_r > actual_pos) ? target_r - actual_pos : actual_pos - target_r;
    wire at_pos = tdiff <= win_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            {sol_a_pwm, sol_b_pwm, err_out, in_pos_out} <= 4'h0;
            {led_green, led_yellow, led_red, ramp_bypass} <= 4'h0;
        end else begin
            sol_a_pwm <= pcnt_r < thr_a_r;
            sol_b_pwm <= pcnt_r < thr_b_r;
            err_out <= err_r;
            led_red <= err_r;
            in_pos_out <= at_pos;
            led_yellow <= at_pos;
            led_green <= supply_ok;
            ramp_bypass <= bypass;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_block_zero_duty: assert property (block |-> ##2 (!sol_a_pwm && !sol_b_pwm))
        else $error("solenoid pulse while outputs blocked");
    a_hold_target: assert property (!start |=> ($stable(target_r) && $stable(code_r)))
        else $error("target moved without start");
    a_preset_pick: assert property (
            start && sel_code == 3'h0 |=> target_r == $past(preset_in))
        else $error("preset not latched on start");
    a_bus_code: assert property (start && fb_r |=> code_r == $past(bus_code_r))
        else $error("fieldbus variant used selection inputs");
    a_input_code: assert property (start && !fb_r |=> code_r == $past(stab_r[7:5]))
        else $error("selection code wrong");
    a_mode_frozen: assert property (state_r == ST_ACT |=> $stable(mode_r))
        else $error("mode changed while active");
    a_break_error: assert property (cb_now |-> ##2 (err_out && led_red))
        else $error("cable break not reported");
    a_in_position: assert property (at_pos |=> (in_pos_out && led_yellow))
        else $error("in position not shown");
    a_ramp_skip: assert property (bypass && !stop |=> setp_r == $past(target_r))
        else $error("ramp not bypassed");
    a_pwm_wrap: assert property (pcnt_r == 32'(PWM_CYC - 1) |=> pcnt_r == 32'h0)
        else $error("pwm period wrong");
    a_enable_state: assert property (!en |=> state_r == ST_DIS)
        else $error("active without enable");
    a_stop_hold: assert property (stop |=> $stable(setp_r))
        else $error("setpoint moved during stop");

    c_profile_seven: cover property (start && sel_code == 3'h7 ##1 target_r == pmem_r[6]);
    c_open_loop: cover property (open_loop && !block ##2 sol_b_pwm);
    c_cable_break: cover property (cb_now ##2 err_out);
    c_closed_drive: cover property (!open_loop && !block ##2 sol_a_pwm);
endmodule : axis_io_mode_control
`default_nettype wire

/* File: logic/axis_io_defs.svh */
/*
 Constants for the axis I/O and mode block: register byte offsets,
 field positions, reset values and timing figures.
 Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
`ifndef AXIS_IO_DEFS_SVH
`define AXIS_IO_DEFS_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ 125000000
`define PWM_HZ 1000
`define DITHER_HZ 100
`define DEB_NS 1000
`define DEB_CYC ((`DEB_NS * 125 + 999) / 1000)
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_RAMP 8'h04
`define OFS_CURR 8'h08
`define OFS_LOOP 8'h0c
`define OFS_DITH 8'h10
`define OFS_STAT 8'h14
`define OFS_TGT 8'h18
`define OFS_PROF 8'h20
`define OFS_PROF_END 8'h38
// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CTRL_FB_BIT 2
`define CTRL_CBE_BIT 3
`define STAT_CBS_BIT 8
`define RST_IMAX 12'hfff
`define RST_KP 8'h10
`define RST_WIN 12'h008
`define DIN_IDLE 8'h03
`endif

/* File: logic/axis_io_pkg.sv */
/*
 Types shared by the axis I/O and mode block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package axis_io_pkg;
    // Discrete inputs, bit 0 is start
    typedef struct packed {
        logic [2:0] prof;
        logic ramp_off;
        logic loop_bypass_input_line;
        logic enable;
        logic stop_n;
        logic start_n;
    } din_t;
    typedef enum logic {ST_DIS = 1'b0, ST_ACT = 1'b1} state_t;
    typedef enum logic [1:0] {MODE_ON = 2'h0, MODE_OFF = 2'h1, MODE_EXT = 2'h2} mode_t;
endpackage : axis_io_pkg

/* File: verif/seq_valve_model.sv */
/*
 Model of the far side: the sequencer that drives the eight discrete
 inputs, and the two valve coils that count PWM on-time.
 Assumes the bench sets the wanted input states right after a clk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module seq_valve_model (
    input wire logic clk,
    input wire logic start,
    input wire logic stop,
    input wire logic enable,
    input wire logic ctrl_off,
    input wire logic ramp_off,
    input wire logic [2:0] code,
    output axis_io_pkg::din_t din,
    input wire logic sol_a,
    input wire logic sol_b,
    input wire logic clr,
    output int on_a,
    output int on_b
);
    import axis_io_pkg::*;
    // -----------------------------------------------------------
    // Pin levels
    // -----------------------------------------------------------
    // Start and stop are pulled to ground when asserted
    assign din = '{prof: code, ramp_off: ramp_off, loop_bypass_input_line: ctrl_off,
                   enable: enable, stop_n: ~stop, start_n: ~start};
    // Coil on-time counters; duty is judged over whole PWM periods
    always_ff @(posedge clk) begin
        if (clr) begin
            on_a <= 0;
            on_b <= 0;
        end else begin
            on_a <= on_a + int'(sol_a);
            on_b <= on_b + int'(sol_b);
        end
    end
endmodule : seq_valve_model
`default_nettype wire

/* File: verif/axis_io_mode_control_tb.sv */
/*
 Self-checking bench for the axis I/O and mode block.
 Assumes the package and defines header of the design, and a short PWM
 period set by parameter to keep the run brief.
*/
`timescale 1ns/10ps
`default_nettype none
`include "axis_io_defs.svh"
module axis_io_mode_control_tb;
    import axis_io_pkg::*;
    localparam int PWM = 256;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, e, clr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    din_t din;
    logic [11:0] preset_in, actual_pos;
    logic cable_break_in, supply_ok, sol_a_pwm, sol_b_pwm, err_out, in_pos_out;
    logic led_green, led_yellow, led_red, ramp_bypass;
    logic s_start, s_stop, s_en, s_off, s_ramp;
    logic [2:0] s_code;
    int on_a, on_b, err_count, tests_run;
    int cyc = 0;
    int prof_m[8];
    // -----------------------------------------------------------
    // Instances
    // -----------------------------------------------------------
    axis_io_mode_control #(.PWM_CYC(PWM), .DITHER_CYC(64)) uut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
        .preset_in(preset_in), .actual_pos(actual_pos), .cable_break_in(cable_break_in),
        .supply_ok(supply_ok), .sol_a_pwm(sol_a_pwm), .sol_b_pwm(sol_b_pwm),
        .err_out(err_out), .in_pos_out(in_pos_out), .led_green(led_green),
        .led_yellow(led_yellow), .led_red(led_red), .ramp_bypass(ramp_bypass));
    seq_valve_model seq (.clk(clk), .start(s_start), .stop(s_stop), .enable(s_en),
        .ctrl_off(s_off), .ramp_off(s_ramp), .code(s_code), .din(din), .sol_a(sol_a_pwm),
        .sol_b(sol_b_pwm), .clr(clr), .on_a(on_a), .on_b(on_b));
    // -----------------------------------------------------------
    // Clock, watchdog and tasks
    // -----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // A hung handshake must still end in the closing report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== x) begin
            $display("BAD %s expected %h seen %h", nm, x, g);
            err_count = err_count + 1;
        end
    endtask : chk
    // One APB transfer; one idle edge after it so psel never toggles twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q & m);
        chk({nm, "_slverr"}, 32'h0, 32'(e));
    endtask : rdchk
    // Input filter needs 2 sync plus 125 debounce cycles, then the pipeline
    task automatic settle;
        repeat (140) @(posedge clk);
    endtask : settle
    // Skip one period so an old duty has ended, then count two periods
    task automatic measure;
        repeat (PWM) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2 * PWM) @(posedge clk);
    endtask : measure
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; preset_in = 12'h000; actual_pos = 12'h000; cable_break_in = 1'b0;
        supply_ok = 1'b1; clr = 1'b0; s_start = 1'b0; s_stop = 1'b0; s_en = 1'b0;
        s_off = 1'b0; s_ramp = 1'b0; s_code = 3'h0; err_count = 0; tests_run = 0;
        void'($urandom(32'hfcb2d493));
        repeat (6) @(posedge clk);
        chk("out_in_reset", 32'h0, {sol_a_pwm, sol_b_pwm, err_out, in_pos_out});
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("led_green", 32'h1, led_green);
        supply_ok <= 1'b0;
        repeat (2) @(posedge clk);
        chk("led_off", 32'h0, led_green);
        supply_ok <= 1'b1;
        rdchk("loop_reg", `OFS_LOOP, 32'h0fff_00ff, 32'h0008_0010);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped_err", 32'h1, e);
        chk("unmapped_data", 32'h0, q);
        for (int i = 1; i < 8; i++) begin
            prof_m[i] = $urandom % 4096;
            apb(1'b1, `OFS_PROF + 8'(4 * (i - 1)), 32'(prof_m[i]));
        end
        for (int i = 1; i < 8; i++) begin
            rdchk("profile", `OFS_PROF + 8'(4 * (i - 1)), 32'hfff, 32'(prof_m[i]));
        end
        // Dither left on for the rest of the run so every drive check sees it
        apb(1'b1, `OFS_DITH, 32'h100);
        rdchk("dither", `OFS_DITH, 32'hfff, 32'h100);
        // Every selection code with start held asserted
        s_en <= 1'b1;
        s_start <= 1'b1;
        s_ramp <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            s_code <= 3'(c);
            preset_in <= 12'($urandom);
            settle();
            rdchk("target", `OFS_TGT, 32'hfff,
                  c == 0 ? 32'(preset_in) : 32'(prof_m[c]));
        end
        s_start <= 1'b0;
        settle();
        s_code <= 3'h5;
        settle();
        rdchk("target_held", `OFS_TGT, 32'hfff, 32'(prof_m[7]));
        // Fieldbus variant, software code 2 while the pins say 5
        s_en <= 1'b0;
        settle();
        apb(1'b1, `OFS_CTRL, 32'h24);
        s_start <= 1'b1;
        s_en <= 1'b1;
        settle();
        rdchk("fieldbus", `OFS_TGT, 32'hfff, 32'(prof_m[2]));
        // Open loop, mode set while disabled and refused while active
        s_en <= 1'b0;
        settle();
        apb(1'b1, `OFS_CTRL, 32'(MODE_OFF));
        s_code <= 3'h0;
        preset_in <= 12'hfff;
        s_en <= 1'b1;
        settle();
        rdchk("mode", `OFS_STAT, 32'h7, {29'h0, MODE_OFF, 1'b1});
        apb(1'b1, `OFS_CTRL, 32'(MODE_ON));
        rdchk("mode_held", `OFS_STAT, 32'h7, {29'h0, MODE_OFF, 1'b1});
        measure();
        chk("open_full", 32'h1, on_a > 0 && on_b == 0);
        preset_in <= 12'h000;
        settle();
        measure();
        chk("open_zero", 32'h1, on_b > 0 && on_a == 0);
        s_stop <= 1'b1;
        settle();
        measure();
        chk("stopped", 32'h0, 32'(on_a + on_b));
        s_stop <= 1'b0;
        s_en <= 1'b0;
        settle();
        measure();
        chk("disabled", 32'h0, 32'(on_a + on_b));
        // External mode: controller-off pin picks the loop type
        apb(1'b1, `OFS_CTRL, 32'(MODE_EXT));
        s_off <= 1'b1;
        s_en <= 1'b1;
        preset_in <= 12'hfff;
        settle();
        measure();
        chk("ext_open", 32'h1, on_a > 0 && on_b == 0);
        s_off <= 1'b0;
        preset_in <= 12'd2000;
        actual_pos <= 12'd2000;
        settle();
        measure();
        chk("closed_zero", 32'h0, 32'(on_a + on_b));
        chk("in_pos", 32'h3, {in_pos_out, led_yellow});
        actual_pos <= 12'd2200;
        settle();
        measure();
        chk("in_pos_far", 32'h0, in_pos_out);
        chk("closed_drive", 32'h1, on_a + on_b > 0);
        // Ramp bypass by pin or by zero ramp time
        s_ramp <= 1'b0;
        apb(1'b1, `OFS_RAMP, 32'h5);
        settle();
        chk("ramp_used", 32'h0, ramp_bypass);
        s_ramp <= 1'b1;
        settle();
        chk("ramp_pin", 32'h1, ramp_bypass);
        apb(1'b1, `OFS_RAMP, 32'h0);
        s_ramp <= 1'b0;
        settle();
        chk("ramp_zero", 32'h1, ramp_bypass);
        // Cable break blocks both coils
        apb(1'b1, `OFS_CTRL, 32'h8 | 32'(MODE_EXT));
        cable_break_in <= 1'b1;
        repeat (4) @(posedge clk);
        chk("error_out", 32'h3, {err_out, led_red});
        measure();
        chk("blocked", 32'h0, 32'(on_a + on_b));
        rdchk("err_stat", `OFS_STAT, 32'h280, 32'h280);
        // Sticky break flag clears by writing bit 8 once the break is gone
        cable_break_in <= 1'b0;
        apb(1'b1, `OFS_STAT, 32'h100);
        rdchk("sticky_clr", `OFS_STAT, 32'h280, 32'h0);
        tally_and_finish();
    end
endmodule : axis_io_mode_control_tb
`default_nettype wire
